//--- logic/adc_ctrl_pkg.sv
// constants and types shared by the converter control block
// assumes a single 200 MHz system clock and synchronous pin inputs
package adc_ctrl_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 5;
    localparam int CONV_TIME_INT_NS = 3600;
    localparam int CONV_STEPS       = 13;
    localparam int ACQ_STEPS        = 3;
    // internal conversion clock period, rounded down to whole cycles
    localparam int INT_TICK_CYCLES  = CONV_TIME_INT_NS / (CONV_STEPS * CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // widths and control byte fields
    // ------------------------------------------------------------
    localparam int RESULT_W   = 12;
    localparam int CTRL_W     = 8;
    localparam int PM_HI_POS  = 7;
    localparam int PM_LO_POS  = 6;
    localparam int ACQ_POS    = 5;
    localparam int SGL_POS    = 4;
    localparam int UNI_POS    = 3;
    localparam int ADDR_LSB   = 0;
    localparam int ADDR_W     = 3;

    // ------------------------------------------------------------
    // encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] PM_SHUTDOWN = 2'h0;
    localparam logic [1:0] PM_STANDBY  = 2'h1;
    localparam logic [1:0] PM_INT_CLK  = 2'h2;
    localparam logic [1:0] PM_EXT_CLK  = 2'h3;
    localparam logic       CLK_MODE_RESET = 1'h1;
    localparam logic       INT_N_RESET    = 1'h1;
    localparam logic [7:0] CTRL_RESET     = 8'hC8;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ACQ_INT = 2'b01,
        ST_ACQ_EXT = 2'b10,
        ST_CONV    = 2'b11
    } seq_t;

endpackage : adc_ctrl_pkg

//--- logic/sar_engine.sv
// successive-approximation register: 12 decisions then one finishing step
// assumes step_in pulses once per conversion clock and comp_in answers the trial code
`timescale 1ns/1ps
module sar_engine
    import adc_ctrl_pkg::*;
#(
    parameter int W = RESULT_W
) (
    input  wire logic         clk_in,      // system clock
    input  wire logic         rst_in,      // sync reset, high
    input  wire logic         start_in,    // begin a conversion
    input  wire logic         step_in,     // conversion clock tick
    input  wire logic         comp_in,     // input at or above trial
    input  wire logic         unipolar_in, // coding select
    output logic [W-1:0]      trial_out,   // trial code to dac
    output logic [W-1:0]      result_out,  // finished code
    output logic              done_out     // one-cycle finish pulse
);

    typedef struct packed {
        logic [W-1:0] code;
        logic [3:0]   cnt;
        logic         busy;
        logic         done;
        logic [W-1:0] result;
    } sar_t;

    sar_t s_reg;
    sar_t s_next;

    always_comb begin
        int bi;
        bi = 0;
        s_next = s_reg;
        s_next.done = 1'b0;
        if (start_in) begin
            s_next.code = {1'b1, {(W-1){1'b0}}};
            s_next.cnt  = 4'h0;
            s_next.busy = 1'b1;
        end else if (step_in && s_reg.busy) begin
            if (s_reg.cnt == 4'(CONV_STEPS - 1)) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
                s_next.result = unipolar_in ? s_reg.code : {~s_reg.code[W-1], s_reg.code[W-2:0]};
            end else begin
                bi = W - 1 - int'(s_reg.cnt);
                if (!comp_in) s_next.code[bi] = 1'b0;
                if (bi != 0) s_next.code[bi-1] = 1'b1;
                s_next.cnt = s_reg.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) s_reg <= '0;
        else s_reg <= s_next;
    end

    assign trial_out  = s_reg.code;
    assign result_out = s_reg.result;
    assign done_out   = s_reg.done;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_bipolar_flip: assert property (@(posedge clk_in) disable iff (rst_in)
        done_out && !$past(unipolar_in) |-> result_out[W-1] == ~$past(s_reg.code[W-1]))
        else $error("bipolar result not two's complement");

endmodule : sar_engine

//--- logic/bus_read_driver.sv
// drives the byte-wide result bus for the read strobe
// assumes strobes are synchronous; output enable high while driving
`timescale 1ns/1ps
module bus_read_driver
    import adc_ctrl_pkg::*;
(
    input  wire logic                clk_in,              // system clock
    input  wire logic                rst_in,              // sync reset, high
    input  wire logic                cs_n_in,             // chip select, low
    input  wire logic                rd_n_in,             // read strobe, low
    input  wire logic                high_byte_select_in, // upper byte select
    input  wire logic [RESULT_W-1:0] result_in,           // held result
    input  wire logic                unipolar_in,         // coding of result
    output logic [CTRL_W-1:0]        data_out,            // bus data
    output logic                     data_oe_out          // bus drive enable
);

    typedef struct packed {
        logic [CTRL_W-1:0] data;
        logic              oe;
    } rdrv_t;

    rdrv_t s_reg;
    rdrv_t s_next;

    always_comb begin
        s_next.oe = !cs_n_in && !rd_n_in;
        s_next.data = 8'h00;
        if (s_next.oe && !high_byte_select_in) s_next.data = result_in[7:0];
        if (s_next.oe && high_byte_select_in)
            s_next.data = {unipolar_in ? 4'h0 : {4{result_in[11]}}, result_in[11:8]};
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) s_reg <= '0;
        else s_reg <= s_next;
    end

    assign data_out    = s_reg.data;
    assign data_oe_out = s_reg.oe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_deselect_hiz: assert property (@(posedge clk_in) disable iff (rst_in)
        cs_n_in |=> !data_oe_out)
        else $error("bus driven while deselected");
    a_low_byte: assert property (@(posedge clk_in) disable iff (rst_in)
        !cs_n_in && !rd_n_in && !high_byte_select_in |=> data_out == $past(result_in[7:0]))
        else $error("low byte wrong");
    a_high_fill: assert property (@(posedge clk_in) disable iff (rst_in)
        !cs_n_in && !rd_n_in && high_byte_select_in
        |=> data_out[7:4] == ($past(unipolar_in) ? 4'h0 : {4{$past(result_in[11])}}))
        else $error("high byte fill wrong");
    c_high_read: cover property (@(posedge clk_in) !cs_n_in && !rd_n_in && high_byte_select_in);

endmodule : bus_read_driver

//--- logic/adc_parallel_host_control.sv
// control and host interface of a 12-bit sar converter with input mux
// assumes pins are synchronous to clk_in; analog front end answers comp_in
`timescale 1ns/1ps

// Notes on behaviour
// - chip select high: clock, write and read ignored, bus undriven.
// - host puts control byte on the data lines during a write; device latches it.
// - byte bits: power mode hi, lo, acquisition, single-ended, unipolar, 3-bit address.
// - unipolar gives straight binary, bipolar gives two's complement.
// - read with select and read low; byte select picks low or upper bits.
// - upper byte read fills bits 7..4 with zero or the sign bit.
// - single-ended: address picks the positive channel, common is negative.
// - differential: address 2..1 pick a pair, bit 0 swaps polarity.
// - reset gives external clock mode and done output high.
// - both power-down modes keep the bus working but stop conversions.
// - standby ends on the next write strobe rising edge.
// - shutdown is entered only after the running conversion ends.
// - write strobe rising edge in shutdown returns to normal operation.
// - result is a 12-bit code, one step is reference over 4096.
// - sequence: one write, three acquisition, thirteen conversion, two read cycles.
// - power field: 00 shutdown, 01 standby, 10 internal, 11 external clock.
// - done output falls on a valid result, rises on read or write.
// - acquisition bit 1 holds acquisition; a matching write with 0 converts.
module adc_parallel_host_control
    import adc_ctrl_pkg::*;
#(
    parameter int NUM_CHANNELS = 8
) (
    input  wire logic                clk_in,              // system clock
    input  wire logic                rst_in,              // sync reset, high
    input  wire logic                cs_n_in,             // chip select, low
    input  wire logic                wr_n_in,             // write strobe, low
    input  wire logic                rd_n_in,             // read strobe, low
    input  wire logic                high_byte_select_in, // upper byte select
    input  wire logic                conv_clk_in,         // external conversion clock
    input  wire logic [CTRL_W-1:0]   data_in,             // bus data in
    input  wire logic                comp_in,             // comparator decision
    output logic [CTRL_W-1:0]        data_out,            // bus data out
    output logic                     data_oe_out,         // bus drive enable
    output logic                     int_n_out,           // conversion done, low
    output logic                     track_out,           // track and hold tracking
    output logic [ADDR_W-1:0]        pos_ch_out,          // positive input channel
    output logic [ADDR_W-1:0]        neg_ch_out,          // negative input channel
    output logic                     neg_is_com_out,      // negative input is common
    output logic                     unipolar_out,        // unipolar input range
    output logic                     ext_clk_mode_out,    // external clock mode
    output logic                     standby_out,         // standby power state
    output logic                     shutdown_out,        // shutdown power state
    output logic [RESULT_W-1:0]      trial_code_out       // sar trial code to dac
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CTRL_W-1:0]   ctrl;
        logic                ext_clk;
        seq_t                st;
        logic                standby;
        logic                shutdown;
        logic [1:0]          pend_pm;
        logic [1:0]          acq_cnt;
        logic [5:0]          div;
        logic                wr_q;
        logic                rd_q;
        logic                clk_q;
        logic                cs_q;
        logic                int_n;
        logic [RESULT_W-1:0] result;
        logic                res_uni;
        logic                sar_start;
        logic                track;
        logic [ADDR_W-1:0]   pos_ch;
        logic [ADDR_W-1:0]   neg_ch;
        logic                neg_com;
    } ctl_t;

    ctl_t s_reg;
    ctl_t s_next;

    logic                wr_edge;
    logic                rd_start;
    logic                clk_edge;
    logic                int_tick;
    logic                tick;
    logic                sar_step;
    logic                sar_done;
    logic                conv_done;
    logic [RESULT_W-1:0] sar_result;

    // the four-channel variant has no upper bank, so the high address bit folds away
    function automatic logic [ADDR_W-1:0] chan_fit(input logic [ADDR_W-1:0] ch);
        chan_fit = (NUM_CHANNELS > 4) ? ch : {1'b0, ch[ADDR_W-2:0]};
    endfunction : chan_fit

    // ------------------------------------------------------------
    // strobe and clock events
    // ------------------------------------------------------------
    // write strobe rising edge, selected
    assign wr_edge   = wr_n_in && !s_reg.wr_q && !s_reg.cs_q;
    assign rd_start  = !rd_n_in && s_reg.rd_q && !cs_n_in;
    assign clk_edge  = conv_clk_in && !s_reg.clk_q && !cs_n_in;
    assign int_tick  = s_reg.div == 6'(INT_TICK_CYCLES - 1);
    assign tick      = s_reg.ext_clk ? clk_edge : int_tick;
    assign sar_step  = tick && (s_reg.st == ST_CONV);
    assign conv_done = sar_done && (s_reg.st == ST_CONV);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.wr_q = wr_n_in;
        s_next.rd_q = rd_n_in;
        s_next.clk_q = conv_clk_in;
        s_next.cs_q = cs_n_in;
        s_next.sar_start = 1'b0;
        s_next.div = (s_reg.ext_clk || int_tick) ? 6'h00 : s_reg.div + 6'h01;

        if (rd_start) s_next.int_n = 1'b1;

        unique case (s_reg.st)
            ST_IDLE: begin
                s_next.track = 1'b0;
            end
            ST_ACQ_EXT: begin
                s_next.track = 1'b1;
            end
            ST_ACQ_INT: begin
                if (tick) begin
                    if (s_reg.acq_cnt == 2'(ACQ_STEPS - 1)) begin
                        s_next.st = ST_CONV;
                        s_next.sar_start = 1'b1;
                        s_next.track = 1'b0;
                    end else begin
                        s_next.acq_cnt = s_reg.acq_cnt + 2'h1;
                    end
                end
            end
            ST_CONV: begin
                if (sar_done) begin
                    s_next.st = ST_IDLE;
                    s_next.shutdown = s_reg.pend_pm == PM_SHUTDOWN;
                    s_next.standby = s_reg.pend_pm == PM_STANDBY;
                end
            end
        endcase

        if (wr_edge) begin
            s_next.ctrl = data_in;
            s_next.int_n = 1'b1;
            s_next.standby = 1'b0;
            s_next.shutdown = 1'b0;
            s_next.pend_pm = data_in[PM_HI_POS:PM_LO_POS];
            if (data_in[PM_HI_POS]) s_next.ext_clk = data_in[PM_LO_POS];
            s_next.acq_cnt = 2'h0;
            s_next.track = 1'b1;
            if (s_reg.st == ST_ACQ_EXT && !data_in[ACQ_POS]
                && data_in[ADDR_W-1:0] == s_reg.ctrl[ADDR_W-1:0]) begin
                s_next.st = ST_CONV;
                s_next.sar_start = 1'b1;
                s_next.track = 1'b0;
            end else if (data_in[ACQ_POS]) begin
                s_next.st = ST_ACQ_EXT;
            end else begin
                s_next.st = ST_ACQ_INT;
            end
        end

        // a finishing conversion wins over a clear in the same cycle
        // result kept apart so a new acquisition leaves it readable
        if (conv_done) begin
            s_next.result = sar_result;
            s_next.res_uni = s_reg.ctrl[UNI_POS];
            s_next.int_n = 1'b0;
        end

        s_next.neg_com = s_next.ctrl[SGL_POS];
        s_next.pos_ch = chan_fit(s_next.ctrl[ADDR_LSB +: ADDR_W]);
        s_next.neg_ch = chan_fit({s_next.ctrl[ADDR_LSB+1 +: ADDR_W-1], ~s_next.ctrl[ADDR_LSB]});
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_reg <= '0;
            s_reg.ctrl <= CTRL_RESET;
            s_reg.ext_clk <= CLK_MODE_RESET;
            s_reg.int_n <= INT_N_RESET;
            s_reg.pend_pm <= PM_EXT_CLK;
            s_reg.wr_q <= 1'h1;
            s_reg.rd_q <= 1'h1;
            s_reg.cs_q <= 1'h1;
            s_reg.neg_com <= CTRL_RESET[SGL_POS];
            s_reg.neg_ch <= 3'h1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // sar and read path
    // ------------------------------------------------------------
    sar_engine #(
        .W           (RESULT_W)
    ) u_sar (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .start_in    (s_reg.sar_start),
        .step_in     (sar_step),
        .comp_in     (comp_in),
        .unipolar_in (s_reg.ctrl[UNI_POS]),
        .trial_out   (trial_code_out),
        .result_out  (sar_result),
        .done_out    (sar_done)
    );

    // read path runs whatever the power state
    bus_read_driver u_rd (
        .clk_in              (clk_in),
        .rst_in              (rst_in),
        .cs_n_in             (cs_n_in),
        .rd_n_in             (rd_n_in),
        .high_byte_select_in (high_byte_select_in),
        .result_in           (s_reg.result),
        .unipolar_in         (s_reg.res_uni),
        .data_out            (data_out),
        .data_oe_out         (data_oe_out)
    );

    assign int_n_out        = s_reg.int_n;
    assign track_out        = s_reg.track;
    assign pos_ch_out       = s_reg.pos_ch;
    assign neg_ch_out       = s_reg.neg_ch;
    assign neg_is_com_out   = s_reg.neg_com;
    assign unipolar_out     = s_reg.ctrl[UNI_POS];
    assign ext_clk_mode_out = s_reg.ext_clk;
    assign standby_out      = s_reg.standby;
    assign shutdown_out     = s_reg.shutdown;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_ctrl_capture: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_edge |=> s_reg.ctrl == $past(data_in))
        else $error("control byte not captured");
    a_no_deselect_write: assert property (@(posedge clk_in) disable iff (rst_in)
        $past(cs_n_in) && cs_n_in && !$past(wr_n_in) && wr_n_in |=> $stable(s_reg.ctrl))
        else $error("write taken while deselected");
    a_reset_state: assert property (@(posedge clk_in) disable iff (rst_in)
        $past(rst_in) |-> int_n_out && ext_clk_mode_out)
        else $error("reset defaults wrong");
    a_single_chan: assert property (@(posedge clk_in) disable iff (rst_in)
        neg_is_com_out |-> pos_ch_out == chan_fit(s_reg.ctrl[ADDR_LSB +: ADDR_W]))
        else $error("single-ended channel wrong");
    a_diff_pair: assert property (@(posedge clk_in) disable iff (rst_in)
        !neg_is_com_out |-> pos_ch_out[2:1] == neg_ch_out[2:1]
        && pos_ch_out[0] == s_reg.ctrl[0] && neg_ch_out[0] == !s_reg.ctrl[0])
        else $error("differential pair wrong");
    a_wake_write: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_edge |=> !standby_out && !shutdown_out)
        else $error("no wake on write");
    a_down_after: assert property (@(posedge clk_in) disable iff (rst_in)
        conv_done && !wr_edge && s_reg.pend_pm == PM_SHUTDOWN |=> shutdown_out)
        else $error("shutdown not entered after conversion");
    a_shut_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        shutdown_out && !wr_edge |=> shutdown_out)
        else $error("shutdown left without write");
    a_clock_keep: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_edge && !data_in[PM_HI_POS] |=> ext_clk_mode_out == $past(ext_clk_mode_out))
        else $error("power-down changed clock mode");
    a_done_low: assert property (@(posedge clk_in) disable iff (rst_in)
        conv_done |=> !int_n_out ##0 s_reg.result == $past(sar_result))
        else $error("done not flagged");
    a_read_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_start && !conv_done |=> int_n_out)
        else $error("done not cleared by read");
    a_acq_three: assert property (@(posedge clk_in) disable iff (rst_in)
        s_reg.st == ST_ACQ_INT && tick && s_reg.acq_cnt == 2'h2 && !wr_edge |=> s_reg.st == ST_CONV)
        else $error("acquisition length wrong");
    a_ext_release: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_edge && s_reg.st == ST_ACQ_EXT && !data_in[ACQ_POS]
        && data_in[2:0] == s_reg.ctrl[2:0] |=> s_reg.st == ST_CONV ##1 !track_out)
        else $error("external acquisition not released");

    c_conv_done: cover property (@(posedge clk_in) disable iff (rst_in) conv_done);
    c_ext_acq: cover property (@(posedge clk_in) disable iff (rst_in)
        s_reg.st == ST_ACQ_EXT ##1 s_reg.st == ST_CONV);
    c_shutdown: cover property (@(posedge clk_in) disable iff (rst_in) $rose(shutdown_out));
    c_standby_wake: cover property (@(posedge clk_in) disable iff (rst_in)
        standby_out ##1 !standby_out);

endmodule : adc_parallel_host_control

//--- verification/host_bus_model.sv
// host model: byte writes and single-byte reads, with byte select, on the parallel port
// assumes the bench clock; it moves its signals on the falling edge
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic       clk_in,   // bench clock
    input  wire logic [7:0] bus_in,   // device bus data
    input  wire logic       oe_in,    // device drives bus
    output logic            cs_n_out, // chip select, low
    output logic            wr_n_out, // write strobe, low
    output logic            rd_n_out, // read strobe, low
    output logic            hbs_out,  // upper byte select
    output logic [7:0]      data_out  // bus data to device
);
    initial {cs_n_out, wr_n_out, rd_n_out, hbs_out, data_out} = 12'hF00;
    task automatic wr(input logic cs, input logic [7:0] b);
        @(negedge clk_in);
        {cs_n_out, wr_n_out, data_out} <= {cs, 1'b0, b};
        @(negedge clk_in);
        wr_n_out <= 1'b1;
        @(negedge clk_in);
        cs_n_out <= 1'b1;
        // a released bus must not keep showing the old byte
        data_out <= ~b;
        @(negedge clk_in);
    endtask : wr
    task automatic rd(input logic cs, input logic h, output logic [7:0] q);
        @(negedge clk_in);
        {cs_n_out, rd_n_out, hbs_out} <= {cs, 1'b0, h};
        repeat (2) @(negedge clk_in);
        q = oe_in ? bus_in : 8'hZZ;
        {cs_n_out, rd_n_out} <= 2'b11;
        // one idle cycle so the registered bus enable has dropped on return
        @(negedge clk_in);
    endtask : rd
    // select held low
    // the conversion clock only reaches the device while selected
    task automatic sel(input logic cs);
        @(negedge clk_in);
        cs_n_out <= cs;
    endtask : sel
endmodule : host_bus_model

//--- verification/adc_parallel_host_control_tb.sv
// self-checking bench for the converter control block
// assumes an external reference; comparator follows a fixed input code
// internal reference unused
// its long settling time never applies to this bench
`timescale 1ns/1ps
module adc_parallel_host_control_tb;
    import adc_ctrl_pkg::*;
    logic clk = 0, rst = 1, cs_n, wr_n, rd_n, hbs, oe, int_n, trk, nc, uni, ext, sb, sd;
    logic [7:0] din, dout, q;
    logic [2:0] pc, ncn;
    logic [11:0] trial, ana = 12'h000;
    int miscompares = 0, checks = 0;
    logic cclk = 0;
    localparam int RESET_WAIT   = 10000 / CLK_PERIOD_NS;
    localparam int EXT_REF_WAIT = 50000 / CLK_PERIOD_NS;
    wire logic [7:0] st = {int_n, ext, oe, nc, uni, sb, sd, 1'b0};
    always #2.5 clk = ~clk;
    // external conversion clock runs free near its top rate
    always #70 cclk = ~cclk;
    adc_parallel_host_control DUT (.clk_in(clk), .rst_in(rst), .cs_n_in(cs_n), .wr_n_in(wr_n),
        .rd_n_in(rd_n), .high_byte_select_in(hbs), .conv_clk_in(cclk), .data_in(din),
        .comp_in(ana >= trial), .data_out(dout), .data_oe_out(oe), .int_n_out(int_n), .track_out(trk),
        .pos_ch_out(pc), .neg_ch_out(ncn), .neg_is_com_out(nc), .unipolar_out(uni),
        .ext_clk_mode_out(ext), .standby_out(sb), .shutdown_out(sd), .trial_code_out(trial));
    host_bus_model h (.clk_in(clk), .bus_in(dout), .oe_in(oe), .cs_n_out(cs_n), .wr_n_out(wr_n),
        .rd_n_out(rd_n), .hbs_out(hbs), .data_out(din));
    task automatic complete_run();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic wait_done();
        int n;
        for (n = 0; n < 2000 && int_n !== 1'b0; n++)
            @(negedge clk);
        if (n == 2000) begin
            miscompares++;
            complete_run();
        end
    endtask : wait_done
    task automatic conv(input logic [7:0] b, input logic [11:0] a, input logic [15:0] e);
        ana = a;
        h.wr(1'b0, b);
        // bus kept still
        // nothing moves on the bus until the result is flagged
        wait_done();
        h.rd(1'b0, 1'b0, q);
        chk(q, e[7:0]);
        h.rd(1'b0, 1'b1, q);
        chk(q, e[15:8]);
    endtask : conv
    task automatic t_single();
        conv(8'h9D, 12'hA5C, 16'h0A5C);
        chk(st, 8'h98);
        chk({5'h00, pc}, 8'h05);
        $display("single-ended unipolar done");
    endtask : t_single
    task automatic t_bipolar();
        conv(8'h83, 12'h2A0, 16'hFAA0);
        chk(st, 8'h80);
        chk({2'b00, pc, ncn}, 8'h1A);
        $display("differential bipolar done");
    endtask : t_bipolar
    task automatic t_power();
        conv(8'h58, 12'h123, 16'h0123);
        chk(st, 8'h9C);
        h.wr(1'b0, 8'h18);
        chk(st, 8'h98);
        wait_done();
        chk(st, 8'h1A);
        h.wr(1'b0, 8'h98);
        chk(st, 8'h98);
        // reference settling wait
        // the external reference needs the shorter wait after shutdown
        repeat (EXT_REF_WAIT) @(negedge clk);
        wait_done();
        $display("power modes done");
    endtask : t_power
    task automatic t_deselect();
        h.wr(1'b1, 8'hC0);
        h.rd(1'b1, 1'b0, q);
        chk(q, 8'hZZ);
        chk(st, 8'h18);
        $display("deselect done");
    endtask : t_deselect
    task automatic t_ext();
        ana = 12'h7E1;
        h.wr(1'b0, 8'hFA);
        chk({7'h00, trk}, 8'h01);
        h.wr(1'b0, 8'hDA);
        repeat (200) @(negedge clk);
        chk({int_n, 3'h0, trial[11:8]}, 8'h88);
        h.sel(1'b0);
        wait_done();
        ana = 12'h3C4;
        h.wr(1'b0, 8'h98);
        h.rd(1'b0, 1'b0, q);
        chk(q, 8'hE1);
        h.rd(1'b0, 1'b1, q);
        chk(q, 8'h07);
        wait_done();
        h.rd(1'b0, 1'b0, q);
        chk(q, 8'hC4);
        $display("external clock and acquisition done");
    endtask : t_ext
    initial begin
        repeat (12) @(negedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(st, 8'hC8);
        $display("reset done");
        // internal reset interval
        // no conversion is started before it has passed
        repeat (RESET_WAIT) @(negedge clk);
        t_single();
        t_bipolar();
        t_power();
        t_deselect();
        t_ext();
        complete_run();
    end
endmodule : adc_parallel_host_control_tb
